// ==== hw/pcr_config_bank.sv ====
// Configuration and identification register bank with array input gating
// Notes on behaviour
// RL1 - Bit 0 enables serial test port
// RL2 - Page bits feed logic; reset to zero
// RL3 - Power register 0 cleared at power-up only
// RL4 - Power0 bit 1 enables automatic power-down
// RL5 - Power0 bit 3 zero means fast mode
// RL6 - Power0 bit 4 gates clock to array
// RL7 - Power0 bit 5 gates clock to macrocells
// RL8 - Power2 bit 0 blocks low address lines
// RL9 - Alternate mode: address from port F, bus
// RL10 - Power2 bits 2-4 gate control inputs
// RL11 - Power2 bit 5 gates latch enable input
// RL12 - Power2 bit 6 gates high-byte write input
// RL13 - Map bits 1-4 from config; 0,7 cleared
// RL14 - Map bits 0-4 apply only in classic mode
// RL15 - Fetch strobe reaches enabled memories only
// RL16 - Read strobe reaches enabled flash memories only
// RL17 - Map bit 7 enables port F peripheral mode
// RL18 - Info0 low nibble: primary flash size
// RL19 - Info0 high nibble: SRAM size
// RL20 - Info1 low nibble: secondary size
// RL21 - Info1 bits 5-4: secondary memory type
// RL22 - Memory selects come from decode array
// RL23 - Software writes zero to unused bits
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
module pcr_config_bank
	import pcr_pkg::*;
#(
	parameter logic [3:0] PRI_SIZE  = 4'h4,
	parameter logic [3:0] SRAM_SIZE = 4'h3,
	parameter logic [3:0] SEC_SIZE  = 4'h2,
	parameter logic [1:0] SEC_TYPE  = 2'h0
) (
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst,
	input  wire logic                    i_power_on_rst,
	input  wire pcr_pkg::pcr_bus_s       i_bus,
	output logic [7:0]                   o_rdata,
	input  wire logic [7:0]              i_stored_space_map,
	input  wire logic                    i_classic_mode,
	input  wire logic                    i_alt16_mode,
	input  wire logic                    i_logic_clock_input,
	input  wire logic [7:0]              i_mcu_addr_lo,
	input  wire logic [3:0]              i_port_f_low_pins,
	input  wire logic [7:4]              i_muxed_bus_upper_lines,
	input  wire logic [2:0]              i_control_inputs,
	input  wire logic                    i_latch_enable,
	input  wire logic                    i_high_byte_write_strobe,
	input  wire logic                    i_program_fetch_strobe_n,
	input  wire logic                    i_data_read_strobe_n,
	input  wire pcr_pkg::pcr_selects_s   i_decode_logic_array,
	output logic                         o_test_port_enable,
	output logic [7:0]                   o_page_bits,
	output logic                         o_auto_power_down,
	output logic                         o_logic_fast_mode,
	output logic                         o_peripheral_mode,
	output pcr_pkg::pcr_array_in_s       o_array_in,
	output pcr_pkg::pcr_selects_s        o_selects,
	output logic                         o_fetch_sram_n,
	output logic                         o_fetch_secondary_n,
	output logic                         o_fetch_primary_n,
	output logic                         o_read_secondary_n,
	output logic                         o_read_primary_n
);
	import pcr_pkg::*;

	logic [7:0] jtag_port_enable_reg;
	logic [7:0] page_select_reg;
	logic [7:0] power_gating_ctrl_0_reg;
	logic [7:0] power_gating_ctrl_2_reg;
	logic [7:0] code_data_space_map_reg;
	logic [7:0] memory_size_info_0;
	logic [7:0] memory_size_info_1;
	logic [7:0] rdata_next;
	logic       map_loaded_reg;
	logic [7:0] addr_lo_src;
	logic [7:0] addr_lo_gated;
	logic       map_active;
	logic       wr_jtag;
	logic       wr_page;
	logic       wr_pwr0;
	logic       wr_pwr2;
	logic       wr_map;
	logic       array_clock_open;
	logic       macrocell_clock_open;
	logic       address_open;
	logic [2:0] control_open;
	logic       latch_enable_open;
	logic       high_write_open;
	logic [4:0] steer_strobe_n;
	logic [4:0] steer_enable;
	logic [4:0] steer_out_n;

	// Identification values are fixed by build parameters; spare bits read as zero
	always_comb begin
		memory_size_info_0      = 8'h00;
		memory_size_info_0[3:0] = PRI_SIZE; // RL18
		memory_size_info_0[7:4] = SRAM_SIZE; // RL19
	end

	always_comb begin
		memory_size_info_1      = 8'h00;
		memory_size_info_1[3:0] = SEC_SIZE; // RL20
		memory_size_info_1[5:4] = SEC_TYPE; // RL21
	end

	// One write enable per register; unmapped offsets decode to none
	always_comb begin
		wr_jtag = 1'b0;
		wr_page = 1'b0;
		wr_pwr0 = 1'b0;
		wr_pwr2 = 1'b0;
		wr_map  = 1'b0;
		if (i_bus.wr) begin
			if (i_bus.addr == OFS_JTAG_EN) begin
				wr_jtag = 1'b1;
			end else if (i_bus.addr == OFS_PAGE) begin
				wr_page = 1'b1;
			end else if (i_bus.addr == OFS_PWR0) begin
				wr_pwr0 = 1'b1;
			end else if (i_bus.addr == OFS_PWR2) begin
				wr_pwr2 = 1'b1;
			end else if (i_bus.addr == OFS_SPACE_MAP) begin
				wr_map = 1'b1;
			end
		end
	end

	// Test port enable keeps only bit 0; the rest read back as zero
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			jtag_port_enable_reg <= RST_JTAG_EN;
		end else if (wr_jtag) begin
			jtag_port_enable_reg <= i_bus.wdata & MASK_JTAG_EN;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			page_select_reg <= RST_PAGE; // RL2
		end else if (wr_page) begin
			page_select_reg <= i_bus.wdata;
		end
	end

	// Power registers hold through the reset pin; only power-on clears them
	always_ff @(posedge i_clk_sys or posedge i_power_on_rst) begin
		if (i_power_on_rst) begin
			power_gating_ctrl_0_reg <= RST_PWR; // RL3
		end else if (wr_pwr0) begin
			power_gating_ctrl_0_reg <= i_bus.wdata & MASK_PWR0;
		end
	end

	// Power register 2 likewise survives the reset pin
	always_ff @(posedge i_clk_sys or posedge i_power_on_rst) begin
		if (i_power_on_rst) begin
			power_gating_ctrl_2_reg <= RST_PWR; // RL3
		end else if (wr_pwr2) begin
			power_gating_ctrl_2_reg <= i_bus.wdata & MASK_PWR2;
		end
	end

	// Stored configuration is a level, so it is loaded by a clocked step after release
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			map_loaded_reg <= 1'b0;
		end else begin
			map_loaded_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			code_data_space_map_reg <= RST_MAP; // RL13
		end else if (!map_loaded_reg) begin
			code_data_space_map_reg <= i_stored_space_map & MASK_MAP_LOAD; // RL13
		end else if (wr_map) begin
			code_data_space_map_reg <= i_bus.wdata & MASK_MAP;
		end
	end

	always_comb begin
		if (i_bus.addr == OFS_JTAG_EN) begin
			rdata_next = jtag_port_enable_reg;
		end else if (i_bus.addr == OFS_PAGE) begin
			rdata_next = page_select_reg;
		end else if (i_bus.addr == OFS_PWR0) begin
			rdata_next = power_gating_ctrl_0_reg;
		end else if (i_bus.addr == OFS_PWR2) begin
			rdata_next = power_gating_ctrl_2_reg;
		end else if (i_bus.addr == OFS_SPACE_MAP) begin
			rdata_next = code_data_space_map_reg;
		end else if (i_bus.addr == OFS_MEM_INFO0) begin
			rdata_next = memory_size_info_0;
		end else if (i_bus.addr == OFS_MEM_INFO1) begin
			rdata_next = memory_size_info_1;
		end else begin
			rdata_next = 8'h00;
		end
	end

	// Read data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			o_rdata <= rdata_next;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Each mode output follows its register bit with no extra delay
	always_comb begin
		o_test_port_enable = jtag_port_enable_reg[BIT_JTAG_EN]; // RL1
	end

	always_comb begin
		o_page_bits = page_select_reg; // RL2
	end

	always_comb begin
		o_auto_power_down = power_gating_ctrl_0_reg[BIT_AUTO_PD]; // RL4
	end

	// Fast mode is the power-on default, so the stored bit is its inverse
	always_comb begin
		o_logic_fast_mode = ~power_gating_ctrl_0_reg[BIT_FAST_OFF]; // RL5
	end

	always_comb begin
		o_peripheral_mode = code_data_space_map_reg[BIT_PERIPH_MODE]; // RL17
	end

	// A set gate bit disconnects its input to save power
	always_comb begin
		array_clock_open     = ~power_gating_ctrl_0_reg[BIT_ARRAY_CLK]; // RL6
		macrocell_clock_open = ~power_gating_ctrl_0_reg[BIT_MCELL_CLK]; // RL7
	end

	always_comb begin
		address_open = ~power_gating_ctrl_2_reg[BIT_ADDR_GATE]; // RL8
	end

	always_comb begin
		latch_enable_open = ~power_gating_ctrl_2_reg[BIT_ALE_GATE]; // RL11
		high_write_open   = ~power_gating_ctrl_2_reg[BIT_WRH_GATE]; // RL12
	end

	// The three control inputs are gated by consecutive bits
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ctrl
			assign control_open[g] = ~power_gating_ctrl_2_reg[BIT_CTRL0_GATE + g]; // RL10
		end
	endgenerate

	// Alternate mode takes the low nibble from port F and the upper one from the bus
	always_comb begin
		if (i_alt16_mode) begin
			addr_lo_src = {i_muxed_bus_upper_lines, i_port_f_low_pins}; // RL9
		end else begin
			addr_lo_src = i_mcu_addr_lo;
		end
	end

	// Blocked lines hold low so the array sees no toggling while it is idle
	generate
		for (g = 0; g < 8; g++) begin : g_addr
			assign addr_lo_gated[g] = addr_lo_src[g] & address_open; // RL8
		end
	endgenerate

	// Clock gating is combinational; a real chip would use a glitch-free cell here
	always_comb begin
		o_array_in                 = '0;
		o_array_in.clk_to_array    = i_logic_clock_input & array_clock_open; // RL6
		o_array_in.clk_to_mcells   = i_logic_clock_input & macrocell_clock_open; // RL7
		o_array_in.addr_lo         = addr_lo_gated; // RL8
		o_array_in.ctrl            = i_control_inputs & control_open; // RL10
		o_array_in.ale             = i_latch_enable & latch_enable_open; // RL11
		o_array_in.high_byte_write = i_high_byte_write_strobe & high_write_open; // RL12
	end

	// Outside classic mode the strobe steering is bypassed: all paths open
	always_comb begin
		if (i_classic_mode) begin
			map_active = 1'b1; // RL14
		end else begin
			map_active = 1'b0;
		end
	end

	// Paths 0 to 2 carry the fetch strobe, paths 3 and 4 the read strobe
	always_comb begin
		steer_strobe_n[0] = i_program_fetch_strobe_n;
		steer_strobe_n[1] = i_program_fetch_strobe_n;
		steer_strobe_n[2] = i_program_fetch_strobe_n;
	end

	always_comb begin
		steer_strobe_n[3] = i_data_read_strobe_n;
		steer_strobe_n[4] = i_data_read_strobe_n;
	end

	// Enable bits are taken in the same order as the paths
	always_comb begin
		steer_enable[0] = code_data_space_map_reg[BIT_FETCH_SRAM]; // RL15
		steer_enable[1] = code_data_space_map_reg[BIT_FETCH_SEC]; // RL15
		steer_enable[2] = code_data_space_map_reg[BIT_FETCH_PRI]; // RL15
	end

	always_comb begin
		steer_enable[3] = code_data_space_map_reg[BIT_READ_SEC]; // RL16
		steer_enable[4] = code_data_space_map_reg[BIT_READ_PRI]; // RL16
	end

	// A closed path holds its active-low strobe high, so that memory never sees it
	generate
		for (g = 0; g < 5; g++) begin : g_steer
			assign steer_out_n[g] = steer_strobe_n[g] | (map_active & ~steer_enable[g]); // RL14
		end
	endgenerate

	always_comb begin
		o_fetch_sram_n      = steer_out_n[0]; // RL15
		o_fetch_secondary_n = steer_out_n[1]; // RL15
		o_fetch_primary_n   = steer_out_n[2]; // RL15
	end

	always_comb begin
		o_read_secondary_n = steer_out_n[3]; // RL16
		o_read_primary_n   = steer_out_n[4]; // RL16
	end

	// Selects are decoded outside this bank and only pass through
	assign o_selects = i_decode_logic_array; // RL22

endmodule : pcr_config_bank

// ==== hw/pcr_pkg.sv ====
// Package for the configuration register bank: offsets, fields, reset values, carriers
package pcr_pkg;

	// Register offsets on the plain register port
	localparam logic [2:0] OFS_JTAG_EN   = 3'h0;
	localparam logic [2:0] OFS_PAGE      = 3'h1;
	localparam logic [2:0] OFS_PWR0      = 3'h2;
	localparam logic [2:0] OFS_PWR2      = 3'h3;
	localparam logic [2:0] OFS_SPACE_MAP = 3'h4;
	localparam logic [2:0] OFS_MEM_INFO0 = 3'h5;
	localparam logic [2:0] OFS_MEM_INFO1 = 3'h6;

	// Field positions
	localparam int BIT_JTAG_EN       = 0;
	localparam int BIT_AUTO_PD       = 1;
	localparam int BIT_FAST_OFF      = 3;
	localparam int BIT_ARRAY_CLK     = 4;
	localparam int BIT_MCELL_CLK     = 5;
	localparam int BIT_ADDR_GATE     = 0;
	localparam int BIT_CTRL0_GATE    = 2;
	localparam int BIT_ALE_GATE      = 5;
	localparam int BIT_WRH_GATE      = 6;
	localparam int BIT_FETCH_SRAM    = 0;
	localparam int BIT_FETCH_SEC     = 1;
	localparam int BIT_FETCH_PRI     = 2;
	localparam int BIT_READ_SEC      = 3;
	localparam int BIT_READ_PRI      = 4;
	localparam int BIT_PERIPH_MODE   = 7;

	// Writable masks: unused positions read as zero
	localparam logic [7:0] MASK_JTAG_EN  = 8'h01;
	localparam logic [7:0] MASK_PWR0     = 8'h3a;
	localparam logic [7:0] MASK_PWR2     = 8'h7d;
	localparam logic [7:0] MASK_MAP      = 8'h9f;
	localparam logic [7:0] MASK_MAP_LOAD = 8'h1e;

	// Reset values
	localparam logic [7:0] RST_JTAG_EN = 8'h00;
	localparam logic [7:0] RST_PAGE    = 8'h00;
	localparam logic [7:0] RST_PWR     = 8'h00;
	localparam logic [7:0] RST_MAP     = 8'h00;

	// Identification codes
	localparam logic [3:0] PRI_SIZE_4MBIT  = 4'h4;
	localparam logic [3:0] PRI_SIZE_8MBIT  = 4'h5;
	localparam logic [3:0] SRAM_SIZE_NONE  = 4'h0;
	localparam logic [3:0] SRAM_SIZE_16K   = 4'h1;
	localparam logic [3:0] SRAM_SIZE_64K   = 4'h3;
	localparam logic [3:0] SEC_SIZE_NONE   = 4'h0;
	localparam logic [3:0] SEC_SIZE_256K   = 4'h2;
	localparam logic [1:0] SEC_TYPE_FLASH  = 2'h0;
	localparam logic [1:0] SEC_TYPE_EEPROM = 2'h1;

	localparam int N_PRI_SECT = 8;
	localparam int N_SEC_SECT = 4;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pcr_bus_s;

	// Gated inputs as the AND array sees them: each follows its source while open, 0 while blocked
	typedef struct packed {
		logic       clk_to_array;
		logic       clk_to_mcells;
		logic [7:0] addr_lo;
		logic [2:0] ctrl;
		logic       ale;
		logic       high_byte_write;
	} pcr_array_in_s;

	typedef struct packed {
		logic [N_PRI_SECT-1:0] primary_sector_selects;
		logic [N_SEC_SECT-1:0] secondary_sector_selects;
		logic                  sram_select;
	} pcr_selects_s;

endpackage : pcr_pkg

// ==== verification/pcr_config_bank_asserts.sv ====
// Port checker for the configuration register bank
`timescale 1ns/10ps
module pcr_config_bank_chk
	import pcr_pkg::*;
(
	input wire logic                  i_clk_sys,
	input wire logic                  i_rst,
	input wire logic                  i_power_on_rst,
	input wire pcr_pkg::pcr_bus_s     i_bus,
	input wire logic                  i_classic_mode,
	input wire logic [2:0]            i_control_inputs,
	input wire logic                  i_latch_enable,
	input wire logic                  i_program_fetch_strobe_n,
	input wire logic                  i_data_read_strobe_n,
	input wire pcr_pkg::pcr_selects_s i_decode_logic_array,
	input wire logic                  o_test_port_enable,
	input wire logic [7:0]            o_page_bits,
	input wire logic                  o_auto_power_down,
	input wire logic                  o_logic_fast_mode,
	input wire pcr_pkg::pcr_array_in_s o_array_in,
	input wire pcr_pkg::pcr_selects_s o_selects,
	input wire logic                  o_fetch_sram_n,
	input wire logic                  o_fetch_secondary_n,
	input wire logic                  o_fetch_primary_n,
	input wire logic                  o_read_secondary_n,
	input wire logic                  o_read_primary_n
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst || i_power_on_rst);
	test_port_a: assert property (i_bus.wr && i_bus.addr == OFS_JTAG_EN |=>
		o_test_port_enable == $past(i_bus.wdata[0])) else $error("test port enable wrong");
	page_load_a: assert property (i_bus.wr && i_bus.addr == OFS_PAGE |=>
		o_page_bits == $past(i_bus.wdata)) else $error("page bits wrong");
	// Pin reset must leave power settings alone, only power-up clears them
	power_hold_a: assert property (disable iff (i_power_on_rst) $rose(i_rst) |=>
		$stable(o_auto_power_down)) else $error("power setting lost on reset pin");
	power_mode_a: assert property (i_bus.wr && i_bus.addr == OFS_PWR0 |=>
		o_auto_power_down == $past(i_bus.wdata[BIT_AUTO_PD])
		&& o_logic_fast_mode != $past(i_bus.wdata[BIT_FAST_OFF])) else $error("power mode wrong");
	ctrl_gate_a: assert property ((o_array_in.ctrl & ~i_control_inputs) == 3'h0
		&& (!o_array_in.ale || i_latch_enable)) else $error("gated input leaks");
	fetch_pass_a: assert property (!i_classic_mode |->
		{o_fetch_sram_n, o_fetch_secondary_n, o_fetch_primary_n} == {3{i_program_fetch_strobe_n}})
		else $error("fetch strobe gated outside classic mode");
	read_block_a: assert property (i_data_read_strobe_n |->
		o_read_secondary_n && o_read_primary_n) else $error("idle read strobe reached memory");
	select_pass_a: assert property (o_selects == i_decode_logic_array)
		else $error("selects differ from decode array");
	cover property (i_bus.wr && i_bus.addr == OFS_PWR0);
	cover property (i_classic_mode && !i_program_fetch_strobe_n);
	cover property (disable iff (i_power_on_rst) $rose(i_rst) && o_auto_power_down);
endmodule : pcr_config_bank_chk
bind pcr_config_bank pcr_config_bank_chk pcr_config_bank_chk_i (.i_clk_sys, .i_rst,
	.i_power_on_rst, .i_bus, .i_classic_mode, .i_control_inputs, .i_latch_enable,
	.i_program_fetch_strobe_n, .i_data_read_strobe_n, .i_decode_logic_array,
	.o_test_port_enable, .o_page_bits, .o_auto_power_down, .o_logic_fast_mode, .o_array_in,
	.o_selects, .o_fetch_sram_n, .o_fetch_secondary_n, .o_fetch_primary_n,
	.o_read_secondary_n, .o_read_primary_n);

// ==== verification/pcr_mcu_model.sv ====
// Microcontroller side model: strobes, address, control and select levels
`timescale 1ns/10ps
module pcr_mcu_model (
	input  wire logic        i_clk_sys,
	output logic      [31:0] o_pins
);
	// Scrambled every cycle so a stale level never passes for a gated one
	always_ff @(posedge i_clk_sys) begin
		o_pins <= (o_pins === 32'hx) ? 32'h5a3c_96e1 : o_pins * 32'h0019_660d + 32'h3c6e_f35f;
	end
endmodule : pcr_mcu_model

// ==== verification/test_pcr_config_bank.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module test_pcr_config_bank;
	import pcr_pkg::*;
	logic          clk = 0, rst = 1, por = 1, classic = 0, alt = 0;
	pcr_bus_s      bus = '0;
	logic [7:0]    rdata, page;
	logic [31:0]   pins;
	logic          tpe, auto_power_down, fast, pm, fs_n, fsec_n, fp_n, rs_n, rp_n;
	pcr_array_in_s ain;
	pcr_selects_s  sel;
	int            err_total = 0, compares = 0;
	initial forever #10 clk = ~clk;
	pcr_mcu_model pcr_mcu_model_i (.i_clk_sys(clk), .o_pins(pins));
	pcr_config_bank #(.PRI_SIZE(4'h5), .SRAM_SIZE(4'h1), .SEC_SIZE(4'h2), .SEC_TYPE(2'h1))
	pcr_config_bank_i (.i_clk_sys(clk), .i_rst(rst), .i_power_on_rst(por), .i_bus(bus),
		.o_rdata(rdata), .i_stored_space_map(8'hff), .i_classic_mode(classic),
		.i_alt16_mode(alt), .i_logic_clock_input(pins[0]), .i_mcu_addr_lo(pins[8:1]),
		.i_port_f_low_pins(pins[12:9]), .i_muxed_bus_upper_lines(pins[16:13]),
		.i_control_inputs(pins[19:17]), .i_latch_enable(pins[20]),
		.i_high_byte_write_strobe(pins[21]), .i_program_fetch_strobe_n(pins[22]),
		.i_data_read_strobe_n(pins[23]), .i_decode_logic_array(pins[31:19]),
		.o_test_port_enable(tpe), .o_page_bits(page), .o_auto_power_down(auto_power_down),
		.o_logic_fast_mode(fast), .o_peripheral_mode(pm), .o_array_in(ain), .o_selects(sel),
		.o_fetch_sram_n(fs_n), .o_fetch_secondary_n(fsec_n), .o_fetch_primary_n(fp_n),
		.o_read_secondary_n(rs_n), .o_read_primary_n(rp_n));
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, exp);
		@(posedge clk);
		#1 chk(rdata, 8'h00);
	endtask : rd
	// Pin reset (0) or power-up reset (1) held two cycles; bus idle two after for the map load
	task automatic pulse(input bit which);
		if (which) por <= 1;
		else rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		por <= 0;
		repeat (2) @(posedge clk);
	endtask : pulse
	task automatic t_reset;
		rd(OFS_PAGE, 8'h00);
		rd(OFS_SPACE_MAP, 8'h1e);
		rd(OFS_MEM_INFO0, 8'h15);
		rd(OFS_MEM_INFO1, 8'h12);
		rd(OFS_PWR0, 8'h00);
	endtask : t_reset
	task automatic t_regs;
		wr(OFS_PAGE, 8'ha5);
		chk(page, 8'ha5);
		wr(OFS_JTAG_EN, 8'h01);
		chk(tpe, 1);
		rd(OFS_JTAG_EN, 8'h01);
		wr(OFS_JTAG_EN, 8'h00);
		chk(tpe, 0);
		wr(3'h7, 8'hff);
		rd(3'h7, 8'h00);
		rd(OFS_PAGE, 8'ha5);
	endtask : t_regs
	task automatic t_power;
		wr(OFS_PWR0, 8'h3a);
		chk({auto_power_down, fast, ain.clk_to_array, ain.clk_to_mcells}, 4'h8);
		wr(OFS_PWR2, 8'h7d);
		chk({ain.addr_lo, ain.ctrl, ain.ale, ain.high_byte_write}, 0);
		pulse(1'b0);
		rd(OFS_PWR0, 8'h3a);
		pulse(1'b1);
		rd(OFS_PWR2, 8'h00);
		alt <= 1;
		@(posedge clk);
		#1 chk(ain.addr_lo, {pins[16:9]});
		chk({ain.ctrl, ain.ale, ain.high_byte_write}, {pins[19:17], pins[20], pins[21]});
		chk({fast, ain.clk_to_array, ain.clk_to_mcells}, {1'b1, pins[0], pins[0]});
	endtask : t_power
	task automatic t_map;
		classic <= 1;
		wr(OFS_SPACE_MAP, 8'h01);
		chk({fs_n, fsec_n, fp_n, rs_n, rp_n}, {pins[22], 4'hf});
		wr(OFS_SPACE_MAP, 8'h9a);
		chk({pm, fs_n, fsec_n, fp_n, rs_n, rp_n},
			{2'b11, pins[22], 1'b1, pins[23], pins[23]});
		classic <= 0;
		alt     <= 0;
		@(posedge clk);
		#1 chk({fs_n, fp_n, rp_n}, {pins[22], pins[22], pins[23]});
		chk(ain.addr_lo, pins[8:1]);
		chk(sel, pins[31:19]);
	endtask : t_map
	task automatic report_and_stop;
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#20000;
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		por <= 0;
		repeat (2) @(posedge clk);
		t_reset;
		t_regs;
		t_power;
		t_map;
		report_and_stop;
	end
endmodule : test_pcr_config_bank
